// ---- hw/dtec_pkg.sv ----
// Package of constants and carriers for the dual timer/event counter block.
package dtec_pkg;

  // Register offsets on the plain register port.
  localparam logic [4:0] DTEC_OFS_C0_VALUE = 5'h0d;
  localparam logic [4:0] DTEC_OFS_C0_CTRL = 5'h0e;
  localparam logic [4:0] DTEC_OFS_C1_HIGH = 5'h0f;
  localparam logic [4:0] DTEC_OFS_C1_LOW = 5'h10;
  localparam logic [4:0] DTEC_OFS_C1_CTRL = 5'h11;
  localparam logic [4:0] DTEC_OFS_IRQ_CTRL0 = 5'h0b;
  localparam logic [4:0] DTEC_OFS_IRQ_CTRL1 = 5'h1e;
  localparam logic [4:0] DTEC_OFS_PORT_A = 5'h12;

  // Control register field positions.
  localparam int DTEC_BIT_EDGE = 3;
  localparam int DTEC_BIT_RUN = 4;
  localparam int DTEC_BIT_C1_SRC = 5;
  localparam int DTEC_BIT_C0_FLAG = 6;
  localparam int DTEC_BIT_C1_FLAG = 4;
  localparam int DTEC_BIT_C0_IRQ_EN = 2;
  localparam int DTEC_BIT_C1_IRQ_EN = 0;
  localparam int DTEC_BIT_PORT_PFD = 3;

  // Reset and readback masks.
  localparam logic [7:0] DTEC_C0_CTRL_RST = 8'h08;
  localparam logic [7:0] DTEC_C1_CTRL_RST = 8'h08;
  localparam logic [7:0] DTEC_C0_CTRL_MASK = 8'hdf;
  localparam logic [7:0] DTEC_C1_CTRL_MASK = 8'hf8;
  localparam logic [7:0] DTEC_IRQ0_MASK = 8'h7f;
  localparam logic [7:0] DTEC_IRQ1_MASK = 8'h77;
  localparam logic [7:0] DTEC_PORT_A_RST = 8'hff;

  // Internal clock figures: system clock over four for counter 1.
  localparam int DTEC_C1_SYS_DIV = 4;
  localparam logic [1:0] DTEC_C1_DIV_LAST = 2'(DTEC_C1_SYS_DIV - 1);

  // Operating modes.
  typedef enum logic [1:0] {
    DTEC_MODE_NONE = 2'b00,
    DTEC_MODE_EVENT = 2'b01,
    DTEC_MODE_TIMER = 2'b10,
    DTEC_MODE_PULSE = 2'b11
  } dtec_mode_e;

  // Register port request.
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtec_req_s;

  // Decoded control for one counter.
  typedef struct packed {
    dtec_mode_e mode;
    logic edge_pol;
    logic run;
  } dtec_ctrl_s;

endpackage : dtec_pkg

// ---- hw/dtec_counter.sv ----
// One count-up timer/event counter with preload, three modes and pulse-width capture.
`timescale 1ns/100ps
`default_nettype none
module dtec_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Control.
  input wire dtec_pkg::dtec_ctrl_s i_ctrl,
  input wire logic i_int_tick,
  input wire logic i_pin_sync,
  input wire logic i_hold,
  // Preload write and stopped-load.
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_load_val,
  // Results.
  output logic [WIDTH-1:0] o_count,
  output logic o_overflow,
  output logic o_pulse_done
);

  logic [WIDTH-1:0] preload_reg;
  logic [WIDTH-1:0] count_reg;
  logic pin_prev_reg;
  logic measuring_reg;
  logic rise;
  logic fall;
  logic start_edge;
  logic stop_edge;
  logic step;

  // Edge detection on the already synchronised pin.
  assign rise = i_pin_sync & ~pin_prev_reg;
  assign fall = ~i_pin_sync & pin_prev_reg;
  // Polarity 1 starts on rising and stops on falling; 0 is the reverse.
  assign start_edge = i_ctrl.edge_pol ? rise : fall;
  assign stop_edge = i_ctrl.edge_pol ? fall : rise;

  // Select the counting event per mode; a read hold blocks the clock.
  always_comb
  begin
    step = 1'b0;
    unique case (i_ctrl.mode)
      dtec_pkg::DTEC_MODE_EVENT: step = i_ctrl.edge_pol ? fall : rise;
      dtec_pkg::DTEC_MODE_TIMER: step = i_int_tick;
      dtec_pkg::DTEC_MODE_PULSE: step = measuring_reg & i_int_tick;
      dtec_pkg::DTEC_MODE_NONE: step = 1'b0;
    endcase
    step = step & i_ctrl.run & ~i_hold;
  end

  assign o_overflow = step & (count_reg == {WIDTH{1'b1}});
  // Measurement ends when the pin returns to its starting level.
  assign o_pulse_done = measuring_reg & stop_edge & i_ctrl.run;

  // Pin history for edges.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pin_prev_reg <= 1'b0;
    else
      pin_prev_reg <= i_pin_sync;
  end

  // Pulse-width arming: one start edge per enable, nothing after completion.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      measuring_reg <= 1'b0;
    else if (i_ctrl.mode != dtec_pkg::DTEC_MODE_PULSE || !i_ctrl.run)
      measuring_reg <= 1'b0;
    else if (o_pulse_done)
      measuring_reg <= 1'b0;
    else if (start_edge && !measuring_reg)
      measuring_reg <= 1'b1;
  end

  // Preload register takes every write.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      preload_reg <= '0;
    else if (i_load)
      preload_reg <= i_load_val;
  end

  // Counter: stopped writes load it too, overflow reloads from preload.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count_reg <= '0;
    else if (i_load && !i_ctrl.run)
      count_reg <= i_load_val;
    else if (o_overflow)
      count_reg <= preload_reg;
    else if (step)
      count_reg <= count_reg + 1'b1;
  end

  assign o_count = count_reg;

endmodule : dtec_counter
`default_nettype wire

// ---- hw/dtec_timer.sv ----
// Top of the dual timer/event counter: registers, prescalers, pin sync and divided output.
// Contract
// - Count up to all ones, reload preload.
// - Overflow sets counter interrupt request flag.
// - Pulse mode counts between start and return.
// - One pulse measured per enable setting.
// - Pulse mode overflow reloads and requests interrupt.
// - Counter 0 prescaler divides by two-power.
// - Counter 0 polarity bit picks active edges.
// - Enable bit starts and stops counting.
// - Mode field selects event, timer, pulse.
// - Counter 1 polarity bit, same meaning.
// - Counter 1 clock: sys/4 or 32768Hz.
// - Enable self-clears only after pulse measurement.
// - Any overflow wakes the halted device.
// - Option picks counter for port output.
// - Cleared irq enable suppresses interrupt service.
// - Stopped preload write also loads counter.
// - Counter read blocks counting clock.
// - Counter 0 prescaler also drives PWM.
// - High byte write/read pairs with buffer.
// - Divided output toggles each overflow.
`timescale 1ns/100ps
`default_nettype none
module dtec_timer #(
  parameter bit PFD_FROM_C1 = 1'b0
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Register port.
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Pins and sources.
  input wire logic i_counter0_value_pin,
  input wire logic i_counter1_value_pin,
  input wire logic i_rtc_32k_tick,
  // Results.
  output logic o_port_a_bit3,
  output logic o_c0_irq,
  output logic o_c1_irq,
  output logic o_wakeup,
  output logic [6:0] o_pwm_prescale
);

  dtec_pkg::dtec_req_s req;
  logic [7:0] c0_ctrl_reg;
  logic [7:0] c1_ctrl_reg;
  logic [7:0] irq0_reg;
  logic [7:0] irq1_reg;
  logic [7:0] port_a_reg;
  logic [7:0] c1_low_buf_reg;
  logic [7:0] rdata_reg;
  logic [6:0] prescale_reg;
  logic [1:0] c1_div_reg;
  logic pin0_meta_reg;
  logic pin0_sync_reg;
  logic pin1_meta_reg;
  logic pin1_sync_reg;
  logic pfd_toggle_reg;
  logic c0_tick;
  logic c1_tick;
  logic [7:0] c0_mask;
  logic hold0;
  logic hold1;
  logic c0_ovf;
  logic c1_ovf;
  logic c0_done;
  logic c1_done;
  logic [7:0] c0_count;
  logic [15:0] c1_count;
  dtec_pkg::dtec_ctrl_s c0_ctrl;
  dtec_pkg::dtec_ctrl_s c1_ctrl;
  logic wr_c0_val;
  logic wr_c1_high;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign wr_c0_val = req.wr && req.addr == dtec_pkg::DTEC_OFS_C0_VALUE;
  assign wr_c1_high = req.wr && req.addr == dtec_pkg::DTEC_OFS_C1_HIGH;

  // Decoded control fields.
  assign c0_ctrl = '{mode: dtec_pkg::dtec_mode_e'(c0_ctrl_reg[7:6]),
                     edge_pol: c0_ctrl_reg[dtec_pkg::DTEC_BIT_EDGE],
                     run: c0_ctrl_reg[dtec_pkg::DTEC_BIT_RUN]};
  assign c1_ctrl = '{mode: dtec_pkg::dtec_mode_e'(c1_ctrl_reg[7:6]),
                     edge_pol: c1_ctrl_reg[dtec_pkg::DTEC_BIT_EDGE],
                     run: c1_ctrl_reg[dtec_pkg::DTEC_BIT_RUN]};

  // Reading a counter value blocks its clock in that cycle; lost counts are accepted.
  assign hold0 = req.rd && req.addr == dtec_pkg::DTEC_OFS_C0_VALUE;
  assign hold1 = req.rd && req.addr == dtec_pkg::DTEC_OFS_C1_HIGH;

  // Two-flop synchronisers on the count pins.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin0_meta_reg <= 1'b0;
      pin0_sync_reg <= 1'b0;
      pin1_meta_reg <= 1'b0;
      pin1_sync_reg <= 1'b0;
    end
    else
    begin
      pin0_meta_reg <= i_counter0_value_pin;
      pin0_sync_reg <= pin0_meta_reg;
      pin1_meta_reg <= i_counter1_value_pin;
      pin1_sync_reg <= pin1_meta_reg;
    end
  end

  // Free-running prescaler chain, shared with the PWM counter.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      prescale_reg <= '0;
    else
      prescale_reg <= prescale_reg + 7'h01;
  end

  assign o_pwm_prescale = prescale_reg;

  // Tick once every 2^n clocks: all low bits below n are ones.
  assign c0_mask = 8'((8'h01 << c0_ctrl_reg[2:0]) - 8'h01);
  assign c0_tick = ({1'b0, prescale_reg} & c0_mask) == c0_mask;

  // Counter 1 internal clock: system over four or the 32768Hz tick.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      c1_div_reg <= '0;
    else
      c1_div_reg <= c1_div_reg + 2'h1;
  end

  assign c1_tick = c1_ctrl_reg[dtec_pkg::DTEC_BIT_C1_SRC] ? i_rtc_32k_tick
                   : (c1_div_reg == dtec_pkg::DTEC_C1_DIV_LAST);

  // The two counters.
  dtec_counter #(.WIDTH(8)) u_c0 (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ctrl(c0_ctrl),
    .i_int_tick(c0_tick),
    .i_pin_sync(pin0_sync_reg),
    .i_hold(hold0),
    .i_load(wr_c0_val),
    .i_load_val(req.wdata),
    .o_count(c0_count),
    .o_overflow(c0_ovf),
    .o_pulse_done(c0_done)
  );

  // High byte write carries the buffered low byte with it.
  dtec_counter #(.WIDTH(16)) u_c1 (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_ctrl(c1_ctrl),
    .i_int_tick(c1_tick),
    .i_pin_sync(pin1_sync_reg),
    .i_hold(hold1),
    .i_load(wr_c1_high),
    .i_load_val({req.wdata, c1_low_buf_reg}),
    .o_count(c1_count),
    .o_overflow(c1_ovf),
    .o_pulse_done(c1_done)
  );

  // Control registers; the run bit self-clears only at pulse completion, a write wins the same cycle.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      c0_ctrl_reg <= dtec_pkg::DTEC_C0_CTRL_RST;
      c1_ctrl_reg <= dtec_pkg::DTEC_C1_CTRL_RST;
    end
    else
    begin
      if (req.wr && req.addr == dtec_pkg::DTEC_OFS_C0_CTRL)
        c0_ctrl_reg <= req.wdata & dtec_pkg::DTEC_C0_CTRL_MASK;
      else if (c0_done)
        c0_ctrl_reg[dtec_pkg::DTEC_BIT_RUN] <= 1'b0;
      if (req.wr && req.addr == dtec_pkg::DTEC_OFS_C1_CTRL)
        c1_ctrl_reg <= req.wdata & dtec_pkg::DTEC_C1_CTRL_MASK;
      else if (c1_done)
        c1_ctrl_reg[dtec_pkg::DTEC_BIT_RUN] <= 1'b0;
    end
  end

  // Low byte holding buffer: written by software, refilled by a high-byte read.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      c1_low_buf_reg <= '0;
    else if (req.wr && req.addr == dtec_pkg::DTEC_OFS_C1_LOW)
      c1_low_buf_reg <= req.wdata;
    else if (hold1)
      c1_low_buf_reg <= c1_count[7:0];
  end

  // Interrupt control registers; a hardware set wins over a software clear.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      irq0_reg <= '0;
      irq1_reg <= '0;
    end
    else
    begin
      if (req.wr && req.addr == dtec_pkg::DTEC_OFS_IRQ_CTRL0)
        irq0_reg <= req.wdata & dtec_pkg::DTEC_IRQ0_MASK;
      if (c0_ovf)
        irq0_reg[dtec_pkg::DTEC_BIT_C0_FLAG] <= 1'b1;
      if (req.wr && req.addr == dtec_pkg::DTEC_OFS_IRQ_CTRL1)
        irq1_reg <= req.wdata & dtec_pkg::DTEC_IRQ1_MASK;
      if (c1_ovf)
        irq1_reg[dtec_pkg::DTEC_BIT_C1_FLAG] <= 1'b1;
    end
  end

  // Interrupt service requests are gated by the per-counter enables.
  assign o_c0_irq = irq0_reg[dtec_pkg::DTEC_BIT_C0_FLAG] & irq0_reg[dtec_pkg::DTEC_BIT_C0_IRQ_EN];
  assign o_c1_irq = irq1_reg[dtec_pkg::DTEC_BIT_C1_FLAG] & irq1_reg[dtec_pkg::DTEC_BIT_C1_IRQ_EN];

  // Wake-up is raised regardless of the interrupt enables.
  assign o_wakeup = c0_ovf | c1_ovf;

  // Port A data latch; bit 3 gates the divided output.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      port_a_reg <= dtec_pkg::DTEC_PORT_A_RST;
    else if (req.wr && req.addr == dtec_pkg::DTEC_OFS_PORT_A)
      port_a_reg <= req.wdata;
  end

  // Divided output toggles on each overflow of the chosen counter, half its overflow rate.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pfd_toggle_reg <= 1'b0;
    else if (PFD_FROM_C1 ? c1_ovf : c0_ovf)
      pfd_toggle_reg <= ~pfd_toggle_reg;
  end

  assign o_port_a_bit3 = pfd_toggle_reg & port_a_reg[dtec_pkg::DTEC_BIT_PORT_PFD];

  // Read data stands one cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_reg <= '0;
    else if (req.rd)
    begin
      unique case (req.addr)
        dtec_pkg::DTEC_OFS_C0_VALUE: rdata_reg <= c0_count;
        dtec_pkg::DTEC_OFS_C0_CTRL: rdata_reg <= c0_ctrl_reg & dtec_pkg::DTEC_C0_CTRL_MASK;
        dtec_pkg::DTEC_OFS_C1_HIGH: rdata_reg <= c1_count[15:8];
        dtec_pkg::DTEC_OFS_C1_LOW: rdata_reg <= c1_low_buf_reg;
        dtec_pkg::DTEC_OFS_C1_CTRL: rdata_reg <= c1_ctrl_reg & dtec_pkg::DTEC_C1_CTRL_MASK;
        dtec_pkg::DTEC_OFS_IRQ_CTRL0: rdata_reg <= irq0_reg;
        dtec_pkg::DTEC_OFS_IRQ_CTRL1: rdata_reg <= irq1_reg;
        dtec_pkg::DTEC_OFS_PORT_A: rdata_reg <= port_a_reg;
        default: rdata_reg <= '0;
      endcase
    end
    else
      rdata_reg <= '0;
  end

  assign o_rdata = rdata_reg;

endmodule : dtec_timer
`default_nettype wire

// ---- bench/dtec_timer_props.sv ----
// Checker of the dual timer/event counter top ports.
`timescale 1ns/100ps
`default_nettype none
module dtec_timer_props (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Register port.
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Results.
  input wire logic o_port_a_bit3,
  input wire logic o_c0_irq,
  input wire logic o_c1_irq,
  input wire logic o_wakeup,
  input wire logic [6:0] o_pwm_prescale
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Unused control bits never show up in read data.
  a_c0_unused: assert property ($past(i_rd && i_addr == dtec_pkg::DTEC_OFS_C0_CTRL) |-> !o_rdata[5])
    else $error("counter 0 control bit 5 read as one");
  a_c1_unused: assert property ($past(i_rd && i_addr == dtec_pkg::DTEC_OFS_C1_CTRL) |-> o_rdata[2:0] == 3'h0)
    else $error("counter 1 control low bits read nonzero");
  // A cleared interrupt enable silences the request at once.
  a_irq0_mask: assert property ($past(i_wr && i_addr == dtec_pkg::DTEC_OFS_IRQ_CTRL0 && !i_wdata[2]) |-> !o_c0_irq)
    else $error("counter 0 request despite cleared enable");
  a_irq1_mask: assert property ($past(i_wr && i_addr == dtec_pkg::DTEC_OFS_IRQ_CTRL1 && !i_wdata[0]) |-> !o_c1_irq)
    else $error("counter 1 request despite cleared enable");
  // A request rises only after an overflow or a software write.
  a_irq0_cause: assert property ($rose(o_c0_irq) |-> $past(o_wakeup) || $past(i_wr && i_addr == dtec_pkg::DTEC_OFS_IRQ_CTRL0))
    else $error("counter 0 request without cause");
  // The flag is sticky: only software removes it.
  a_irq0_sticky: assert property ($fell(o_c0_irq) |-> $past(i_wr && i_addr == dtec_pkg::DTEC_OFS_IRQ_CTRL0))
    else $error("counter 0 request dropped by itself");
  a_pfd_off: assert property ($past(i_wr && i_addr == dtec_pkg::DTEC_OFS_PORT_A && !i_wdata[3]) |-> !o_port_a_bit3)
    else $error("divided output not forced low");
  // The divided output moves only on an overflow or a port write.
  a_pfd_cause: assert property ($changed(o_port_a_bit3) |-> $past(o_wakeup) || $past(i_wr && i_addr == dtec_pkg::DTEC_OFS_PORT_A))
    else $error("divided output moved without cause");
  // The first edge after reset release still compares against the reset value, so it is skipped.
  a_prescale_run: assert property ($past(i_rst_n) |-> o_pwm_prescale == $past(o_pwm_prescale) + 7'h01)
    else $error("shared prescaler did not step");
  c_wake: cover property (o_wakeup);
  c_irq0: cover property ($rose(o_c0_irq));
  c_pfd: cover property ($changed(o_port_a_bit3));
endmodule // dtec_timer_props
`default_nettype wire

// ---- bench/dtec_pin_src.sv ----
// Model of an external level source on one count pin.
`timescale 1ns/100ps
`default_nettype none
module dtec_pin_src (
  // Clock.
  input wire logic i_ref_clk,
  // Pin.
  output var logic o_pin
);
  // The pin rests low; levels last whole cycles so the sync stage never sees a runt.
  initial o_pin = 1'b0;
  // Move the pin just after an edge and hold it for n cycles.
  task automatic level(input logic v, input int n);
    @(posedge i_ref_clk);
    o_pin <= v;
    repeat (n) @(posedge i_ref_clk);
  endtask
endmodule // dtec_pin_src
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench of the dual timer/event counter top.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_rtc_32k_tick = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] o_rdata;
  logic [15:0] v;
  logic pin0, pin1, o_port_a_bit3, o_c0_irq, o_c1_irq, o_wakeup;
  logic [6:0] o_pwm_prescale;
  logic [15:0] expq[$];
  logic [31:0] lfsr = 32'hbb63;
  int n_fail = 0;
  int checked = 0;
  int k;
  // Clock of 50 ns.
  initial forever #25 i_ref_clk = ~i_ref_clk;
  dtec_timer uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_counter0_value_pin(pin0), .i_counter1_value_pin(pin1),
    .i_rtc_32k_tick(i_rtc_32k_tick), .o_port_a_bit3(o_port_a_bit3), .o_c0_irq(o_c0_irq), .o_c1_irq(o_c1_irq),
    .o_wakeup(o_wakeup), .o_pwm_prescale(o_pwm_prescale));
  dtec_pin_src src0 (.i_ref_clk(i_ref_clk), .o_pin(pin0));
  dtec_pin_src src1 (.i_ref_clk(i_ref_clk), .o_pin(pin1));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim;
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // A read notes its expectation; the watcher below compares it in the answer cycle.
  task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    expq.push_back({m, e});
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  always @(posedge i_ref_clk) rd_d <= i_rd;
  always @(negedge i_ref_clk)
    if (rd_d && expq.size() > 0)
    begin
      v = expq.pop_front();
      chk(o_rdata & v[15:8], v[7:0]);
    end
  // Counter 1 is read high byte first, which latches the low byte for the second read.
  task automatic rdc(input bit c, input logic [7:0] e);
    if (c)
      rd(dtec_pkg::DTEC_OFS_C1_HIGH, 8'h00);
    rd(c ? dtec_pkg::DTEC_OFS_C1_LOW : dtec_pkg::DTEC_OFS_C0_VALUE, e);
  endtask
  task automatic pin(input bit c, input logic l, input int n);
    if (c)
      src1.level(l, n);
    else
      src0.level(l, n);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge i_ref_clk);
      i_rtc_32k_tick <= 1'b1;
      @(posedge i_ref_clk);
      i_rtc_32k_tick <= 1'b0;
    end
  endtask
  // Event mode: one rising then one falling edge; only the chosen edge counts.
  task automatic ev(input bit c, input bit p);
    wr(c ? dtec_pkg::DTEC_OFS_C1_LOW : dtec_pkg::DTEC_OFS_C0_VALUE, 8'h00);
    if (c)
      wr(dtec_pkg::DTEC_OFS_C1_HIGH, 8'h00);
    wr(c ? dtec_pkg::DTEC_OFS_C1_CTRL : dtec_pkg::DTEC_OFS_C0_CTRL, {4'h5, p, 3'h0});
    pin(c, 1'b1, 8);
    rdc(c, {7'h00, !p});
    pin(c, 1'b0, 8);
    rdc(c, 8'h01);
    wr(c ? dtec_pkg::DTEC_OFS_C1_CTRL : dtec_pkg::DTEC_OFS_C0_CTRL, 8'h00);
  endtask
  task automatic wait_wake(input int lim);
    int t = 0;
    while (o_wakeup !== 1'b1 && t < lim)
    begin
      @(negedge i_ref_clk);
      t++;
    end
    if (t >= lim)
    begin
      n_fail++;
      end_sim();
    end
  endtask
  // Hang guard.
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    n_fail++;
    end_sim();
  end
  initial
  begin
    repeat (4) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(dtec_pkg::DTEC_OFS_C0_CTRL, 8'h08);
    rd(dtec_pkg::DTEC_OFS_C1_CTRL, 8'h08);
    rd(dtec_pkg::DTEC_OFS_PORT_A, 8'hff);
    rd(5'h1f, 8'h00);
    wr(dtec_pkg::DTEC_OFS_C0_CTRL, 8'hef);
    rd(dtec_pkg::DTEC_OFS_C0_CTRL, 8'hcf);
    wr(dtec_pkg::DTEC_OFS_C1_CTRL, 8'hef);
    rd(dtec_pkg::DTEC_OFS_C1_CTRL, 8'he8);
    // Each prescale code: exactly four ticks fit in four of its periods.
    for (k = 0; k < 8; k++)
    begin
      lfsr = nxt(lfsr);
      wr(dtec_pkg::DTEC_OFS_C0_VALUE, {1'b0, lfsr[6:0]});
      wr(dtec_pkg::DTEC_OFS_C0_CTRL, 8'h90 | 8'(k));
      repeat ((4 << k) - 2) @(posedge i_ref_clk);
      wr(dtec_pkg::DTEC_OFS_C0_CTRL, 8'(k));
      rd(dtec_pkg::DTEC_OFS_C0_VALUE, {1'b0, lfsr[6:0]} + 8'h04);
    end
    // A running preload write must not disturb the count before overflow.
    wr(dtec_pkg::DTEC_OFS_IRQ_CTRL0, 8'h04);
    wr(dtec_pkg::DTEC_OFS_C0_VALUE, 8'hf0);
    wr(dtec_pkg::DTEC_OFS_C0_CTRL, 8'h90);
    wr(dtec_pkg::DTEC_OFS_C0_VALUE, 8'h20);
    wait_wake(30);
    wr(dtec_pkg::DTEC_OFS_C0_CTRL, 8'h00);
    rd(dtec_pkg::DTEC_OFS_C0_VALUE, 8'h20, 8'hf0);
    rd(dtec_pkg::DTEC_OFS_IRQ_CTRL0, 8'h44);
    @(negedge i_ref_clk);
    chk({7'h00, o_c0_irq}, 8'h01);
    chk({7'h00, o_port_a_bit3}, 8'h01);
    wr(dtec_pkg::DTEC_OFS_IRQ_CTRL0, 8'h40);
    wr(dtec_pkg::DTEC_OFS_PORT_A, 8'hf7);
    @(negedge i_ref_clk);
    chk({7'h00, o_c0_irq}, 8'h00);
    chk({7'h00, o_port_a_bit3}, 8'h00);
    wr(dtec_pkg::DTEC_OFS_IRQ_CTRL0, 8'h00);
    // Counter 1 overflow on the system clock over four.
    wr(dtec_pkg::DTEC_OFS_IRQ_CTRL1, 8'h01);
    wr(dtec_pkg::DTEC_OFS_C1_LOW, 8'hf0);
    wr(dtec_pkg::DTEC_OFS_C1_HIGH, 8'hff);
    wr(dtec_pkg::DTEC_OFS_C1_CTRL, 8'h90);
    wait_wake(90);
    wr(dtec_pkg::DTEC_OFS_C1_CTRL, 8'h00);
    rd(dtec_pkg::DTEC_OFS_C1_HIGH, 8'hff);
    rd(dtec_pkg::DTEC_OFS_C1_LOW, 8'hf0, 8'hf0);
    rd(dtec_pkg::DTEC_OFS_IRQ_CTRL1, 8'h11);
    @(negedge i_ref_clk);
    chk({7'h00, o_c1_irq}, 8'h01);
    wr(dtec_pkg::DTEC_OFS_IRQ_CTRL1, 8'h00);
    for (k = 0; k < 4; k++)
      ev(k[1], k[0]);
    // Counter 0 pulse width with falling start: each clock counts while the pin stays low.
    lfsr = nxt(lfsr);
    k = 4 + int'(lfsr[3:0]);
    wr(dtec_pkg::DTEC_OFS_C0_VALUE, 8'h00);
    pin(1'b0, 1'b1, 6);
    wr(dtec_pkg::DTEC_OFS_C0_CTRL, 8'hd0);
    pin(1'b0, 1'b0, k);
    pin(1'b0, 1'b1, 6);
    rd(dtec_pkg::DTEC_OFS_C0_CTRL, 8'hc0);
    rd(dtec_pkg::DTEC_OFS_C0_VALUE, 8'(k + 1));
    // Pulse width timed by the slow tick; a second pulse must leave the result alone.
    lfsr = nxt(lfsr);
    wr(dtec_pkg::DTEC_OFS_C1_LOW, 8'h00);
    wr(dtec_pkg::DTEC_OFS_C1_HIGH, 8'h00);
    wr(dtec_pkg::DTEC_OFS_C1_CTRL, 8'hf8);
    pin(1'b1, 1'b1, 6);
    tick(1 + lfsr[3:0]);
    pin(1'b1, 1'b0, 6);
    rd(dtec_pkg::DTEC_OFS_C1_CTRL, 8'he8);
    pin(1'b1, 1'b1, 6);
    tick(3);
    pin(1'b1, 1'b0, 6);
    rdc(1'b1, 8'h01 + lfsr[3:0]);
    end_sim();
  end
endmodule // tb
bind dtec_timer dtec_timer_props chk_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_port_a_bit3(o_port_a_bit3),
  .o_c0_irq(o_c0_irq), .o_c1_irq(o_c1_irq), .o_wakeup(o_wakeup), .o_pwm_prescale(o_pwm_prescale));
`default_nettype wire
